// [core/sp_serial_port.sv]
// Serial port data, status and control registers with transmitter and receiver
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module sp_serial_port
(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cpu_status_word_ie,
   input  wire logic        tx_complete_ack,
   input  wire logic        receive_pin,
   output logic             receive_pin_owned,
   output logic             transmit_pin,
   output logic             transmit_pin_oe,
   output logic             rx_complete_irq,
   output logic             tx_complete_irq,
   output logic             buffer_empty_irq
);

   function automatic logic [3:0] char_bits(input logic [2:0] code);
      case (code)
         3'b000:  char_bits = 4'h5;
         3'b001:  char_bits = 4'h6;
         3'b010:  char_bits = 4'h7;
         3'b111:  char_bits = 4'h9;
         default: char_bits = 4'h8; // Reserved codes fall back to eight bits
      endcase
   endfunction : char_bits

   function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                               input logic par_en, input logic odd);
      logic p;
      p = odd;
      build_frame = '1;
      build_frame[0] = 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         if (i < int'(n))
         begin
            build_frame[i + 1] = d[i];
            p = p ^ d[i];
         end
      end
      if (par_en)
         build_frame[int'(n) + 1] = p;
   endfunction : build_frame

   logic [7:0]          ctrl_c;
   logic [11:0]         baud;
   logic                rx_irq_en;
   logic                tx_irq_en;
   logic                udr_irq_en;
   logic                rx_en;
   logic                tx_en;
   logic                size_high;
   logic                tx_ninth;
   logic                double_speed;
   logic                multiproc_mode;
   logic                txc;
   logic                dor;
   logic [11:0]         baud_cnt;
   logic                tick;
   logic [8:0]          tx_buf;
   logic                tx_buf_valid;
   logic                tx_running;
   sp_pkg::sp_tx_state_t tx_state;
   logic [4:0]          tx_sub;
   logic [3:0]          tx_left;
   logic [12:0]         tx_shift;
   sp_pkg::sp_rx_state_t rx_state;
   logic [4:0]          rx_sub;
   logic [3:0]          rx_cnt;
   logic [12:0]         rx_shift;
   sp_pkg::sp_rx_entry_t rx_fifo [0:1];
   sp_pkg::sp_rx_entry_t pend;
   logic                pend_valid;
   logic                rd_ptr;
   logic [1:0]          fifo_cnt;

   logic                acc;
   logic                wr;
   logic                rd;
   logic [3:0]          nbits;
   logic                par_en;
   logic                par_odd;
   logic [4:0]          period;
   logic [4:0]          half;
   logic [3:0]          rx_total;
   logic [3:0]          tx_total;
   logic                tx_load;
   logic                tx_bit_end;
   logic                tx_done;
   logic                rx_start;
   logic                rx_sample;
   logic                push;
   logic                pop;
   logic                head_valid;
   sp_pkg::sp_rx_entry_t head;
   sp_pkg::sp_rx_entry_t rx_entry;
   logic                rx_keep;
   logic [31:0]         next_prdata;
   logic                next_pslverr;

   assign acc        = psel & penable & ~pready;
   assign wr         = acc & pwrite;
   assign rd         = acc & ~pwrite;
   assign nbits      = char_bits({size_high, ctrl_c[sp_pkg::C_SIZE_MSB:sp_pkg::C_SIZE_LSB]});
   assign par_en     = ctrl_c[sp_pkg::C_PAR_HIGH];
   assign par_odd    = ctrl_c[sp_pkg::C_PAR_HIGH] & ctrl_c[sp_pkg::C_PAR_LOW];
   assign period     = double_speed ? sp_pkg::DIV_DOUBLE : sp_pkg::DIV_NORMAL;
   assign half       = period >> 1;
   assign rx_total   = 4'h2 + nbits + {3'b000, par_en};
   assign tx_total   = rx_total + {3'b000, ctrl_c[sp_pkg::C_TWO_STOP]};
   assign head_valid = (fifo_cnt != 2'b00);
   assign head       = rx_fifo[rd_ptr];
   assign pop        = rd && (paddr == sp_pkg::OFF_DATA) && head_valid;
   assign push       = pend_valid && (fifo_cnt != sp_pkg::FIFO_DEPTH);
   assign tx_load    = tx_running && (tx_state == sp_pkg::TX_IDLE) && tx_buf_valid;
   assign tx_bit_end = (tx_state == sp_pkg::TX_SHIFT) && tick && (tx_sub == period - 5'h01);
   assign tx_done    = tx_bit_end && (tx_left == 4'h1);
   assign rx_start   = rx_en && (rx_state == sp_pkg::RX_IDLE) && tick && !receive_pin;
   assign rx_sample  = (rx_state == sp_pkg::RX_RUN) && tick && (rx_sub == half);

   // Received frame unpacking
   always_comb
   begin
      logic [12:0] frame;
      logic        p;
      frame = rx_shift >> (4'hD - rx_total);
      p = par_odd;
      rx_entry = '0;
      for (int i = 0; i < 9; i++)
      begin
         if (i < int'(nbits))
         begin
            rx_entry.data[i] = frame[i + 1];
            p = p ^ frame[i + 1];
         end
      end
      rx_entry.parity_err = par_en && (frame[int'(nbits) + 1] != p);
      rx_entry.frame_err  = !frame[int'(nbits) + 1 + int'(par_en)];
      // Address marker is the ninth bit, or the first stop bit for shorter characters
      if (nbits == 4'h9)
         rx_keep = !multiproc_mode || rx_entry.data[8];
      else
         rx_keep = !multiproc_mode || !rx_entry.frame_err;
   end

   // Register read mux
   always_comb
   begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (paddr)
         sp_pkg::OFF_DATA:
            next_prdata[7:0] = head_valid ? head.data[7:0] : 8'h00;
         sp_pkg::OFF_STAT_A:
            next_prdata[7:0] = {head_valid, txc, !tx_buf_valid, head_valid & head.frame_err, dor,
                                head_valid & head.parity_err, double_speed, multiproc_mode};
         sp_pkg::OFF_CTRL_B:
            next_prdata[7:0] = {rx_irq_en, tx_irq_en, udr_irq_en, rx_en, tx_en, size_high,
                                head_valid & head.data[8], tx_ninth};
         sp_pkg::OFF_CTRL_C:
            next_prdata[7:0] = ctrl_c;
         sp_pkg::OFF_BAUD:
            next_prdata[11:0] = baud;
         default:
            next_pslverr = 1'b1;
      endcase
   end

   // Bus slave: one wait state on every access
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= acc;
         prdata  <= rd ? next_prdata : 32'h0000_0000;
         pslverr <= acc & next_pslverr;
      end
   end

   // Control registers; read-only status bits ignore writes
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         {rx_irq_en, tx_irq_en, udr_irq_en, rx_en, tx_en, size_high} <= sp_pkg::CTRL_B_RESET[7:2];
         tx_ninth       <= sp_pkg::CTRL_B_RESET[sp_pkg::B_TX_NINTH];
         double_speed   <= sp_pkg::STAT_A_RESET[sp_pkg::A_DOUBLE];
         multiproc_mode <= sp_pkg::STAT_A_RESET[sp_pkg::A_MPCM];
         ctrl_c         <= sp_pkg::CTRL_C_RESET;
         baud           <= sp_pkg::BAUD_RESET;
      end
      else if (wr)
      begin
         case (paddr)
            sp_pkg::OFF_STAT_A:
            begin
               double_speed   <= pwdata[sp_pkg::A_DOUBLE];
               multiproc_mode <= pwdata[sp_pkg::A_MPCM];
            end
            sp_pkg::OFF_CTRL_B:
            begin
               rx_irq_en  <= pwdata[sp_pkg::B_RXCIE];
               tx_irq_en  <= pwdata[sp_pkg::B_TXCIE];
               udr_irq_en <= pwdata[sp_pkg::B_UDRIE];
               rx_en      <= pwdata[sp_pkg::B_RXEN];
               tx_en      <= pwdata[sp_pkg::B_TXEN];
               size_high  <= pwdata[sp_pkg::B_SIZE_HIGH];
               tx_ninth   <= pwdata[sp_pkg::B_TX_NINTH];
            end
            sp_pkg::OFF_CTRL_C:
               ctrl_c <= pwdata[7:0];
            sp_pkg::OFF_BAUD:
               baud <= pwdata[11:0];
            default:
               ;
         endcase
      end
   end

   // Oversampling tick; a baud write restarts the prescaler at once
   always_ff @(posedge sys_clk)
   begin
      if (reset || (wr && paddr == sp_pkg::OFF_BAUD))
      begin
         baud_cnt <= 12'h000;
         tick     <= 1'b0;
      end
      else
      begin
         tick     <= (baud_cnt == baud);
         baud_cnt <= (baud_cnt == baud) ? 12'h000 : baud_cnt + 12'h001;
      end
   end

   // Transmit buffer and deferred disable
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tx_buf       <= 9'h000;
         tx_buf_valid <= 1'b0;
         tx_running   <= 1'b0;
      end
      else
      begin
         if (wr && paddr == sp_pkg::OFF_DATA && !tx_buf_valid)
         begin
            tx_buf       <= {tx_ninth, pwdata[7:0]};
            tx_buf_valid <= 1'b1;
         end
         else if (tx_load)
            tx_buf_valid <= 1'b0;
         if (tx_en)
            tx_running <= 1'b1;
         else if (tx_state == sp_pkg::TX_IDLE && !tx_buf_valid)
            tx_running <= 1'b0;
      end
   end

   // Transmit shifter
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tx_state        <= sp_pkg::TX_IDLE;
         tx_sub          <= 5'h00;
         tx_left         <= 4'h0;
         tx_shift        <= '1;
         transmit_pin    <= 1'b1;
         transmit_pin_oe <= 1'b0;
      end
      else
      begin
         transmit_pin_oe <= tx_running | tx_en;
         if (tx_load)
         begin
            tx_state     <= sp_pkg::TX_SHIFT;
            tx_shift     <= build_frame(tx_buf, nbits, par_en, par_odd) >> 1;
            tx_left      <= tx_total;
            tx_sub       <= 5'h00;
            transmit_pin <= 1'b0;
         end
         else if (tx_state == sp_pkg::TX_SHIFT && tick)
         begin
            tx_sub <= tx_bit_end ? 5'h00 : tx_sub + 5'h01;
            if (tx_done)
            begin
               tx_state     <= sp_pkg::TX_IDLE;
               transmit_pin <= 1'b1;
            end
            else if (tx_bit_end)
            begin
               transmit_pin <= tx_shift[0];
               tx_shift     <= {1'b1, tx_shift[12:1]};
               tx_left      <= tx_left - 4'h1;
            end
         end
      end
   end

   // Transmit complete; a new completion wins over a clear
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         txc <= sp_pkg::STAT_A_RESET[sp_pkg::A_TXC];
      else if (tx_done && !tx_buf_valid)
         txc <= 1'b1;
      else if (tx_complete_ack || (wr && paddr == sp_pkg::OFF_STAT_A && pwdata[sp_pkg::A_TXC]))
         txc <= 1'b0;
   end

   // Receiver sampling at mid-bit
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rx_state <= sp_pkg::RX_IDLE;
         rx_sub   <= 5'h00;
         rx_cnt   <= 4'h0;
         rx_shift <= 13'h0000;
      end
      else if (!rx_en)
         rx_state <= sp_pkg::RX_IDLE;
      else
      begin
         case (rx_state)
            sp_pkg::RX_IDLE:
               if (rx_start)
               begin
                  rx_state <= sp_pkg::RX_RUN;
                  rx_sub   <= 5'h00;
                  rx_cnt   <= 4'h0;
               end
            sp_pkg::RX_RUN:
               if (tick)
               begin
                  rx_sub <= (rx_sub == period - 5'h01) ? 5'h00 : rx_sub + 5'h01;
                  if (rx_sample)
                  begin
                     rx_shift <= {receive_pin, rx_shift[12:1]};
                     rx_cnt   <= rx_cnt + 4'h1;
                     // Glitch shorter than half a bit is not a start
                     if (rx_cnt == 4'h0 && receive_pin)
                        rx_state <= sp_pkg::RX_IDLE;
                     else if (rx_cnt == rx_total - 4'h1)
                        rx_state <= sp_pkg::RX_DONE;
                  end
               end
            sp_pkg::RX_DONE:
               rx_state <= sp_pkg::RX_IDLE;
            default:
               rx_state <= sp_pkg::RX_IDLE;
         endcase
      end
   end

   // Pending character and two-entry receive FIFO
   always_ff @(posedge sys_clk)
   begin
      if (reset || !rx_en)
      begin
         pend_valid <= 1'b0;
         pend       <= '0;
         rd_ptr     <= 1'b0;
         fifo_cnt   <= 2'b00;
         rx_fifo[0] <= '0;
         rx_fifo[1] <= '0;
      end
      else
      begin
         if (rx_state == sp_pkg::RX_DONE && rx_keep)
         begin
            pend       <= rx_entry;
            pend_valid <= 1'b1;
         end
         else if (push)
            pend_valid <= 1'b0;
         if (push)
            rx_fifo[rd_ptr ^ fifo_cnt[0]] <= pend;
         if (pop)
            rd_ptr <= ~rd_ptr;
         fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   // Overrun; a new overrun wins over the clearing read
   always_ff @(posedge sys_clk)
   begin
      if (reset || !rx_en)
         dor <= 1'b0;
      else if (rx_start && fifo_cnt == sp_pkg::FIFO_DEPTH && pend_valid)
         dor <= 1'b1;
      else if (rd && paddr == sp_pkg::OFF_DATA)
         dor <= 1'b0;
   end

   // Interrupt requests and pin ownership
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rx_complete_irq   <= 1'b0;
         tx_complete_irq   <= 1'b0;
         buffer_empty_irq  <= 1'b0;
         receive_pin_owned <= 1'b0;
      end
      else
      begin
         rx_complete_irq   <= rx_irq_en & cpu_status_word_ie & head_valid;
         tx_complete_irq   <= tx_irq_en & cpu_status_word_ie & txc;
         buffer_empty_irq  <= udr_irq_en & cpu_status_word_ie & !tx_buf_valid;
         receive_pin_owned <= rx_en;
      end
   end

endmodule : sp_serial_port

// [core/sp_pkg.sv]
// Constants, types and register map of the serial port register block
package sp_pkg;

   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFF_DATA     = 8'h00;
   localparam logic [7:0]  OFF_STAT_A   = 8'h04;
   localparam logic [7:0]  OFF_CTRL_B   = 8'h08;
   localparam logic [7:0]  OFF_CTRL_C   = 8'h0C;
   localparam logic [7:0]  OFF_BAUD     = 8'h10;

   localparam int          A_TXC        = 6;
   localparam int          A_DOUBLE     = 1;
   localparam int          A_MPCM       = 0;
   localparam int          B_RXCIE      = 7;
   localparam int          B_TXCIE      = 6;
   localparam int          B_UDRIE      = 5;
   localparam int          B_RXEN       = 4;
   localparam int          B_TXEN       = 3;
   localparam int          B_SIZE_HIGH  = 2;
   localparam int          B_TX_NINTH   = 0;
   localparam int          C_PAR_HIGH   = 5;
   localparam int          C_PAR_LOW    = 4;
   localparam int          C_TWO_STOP   = 3;
   localparam int          C_SIZE_MSB   = 2;
   localparam int          C_SIZE_LSB   = 1;

   localparam logic [7:0]  STAT_A_RESET = 8'h00;
   localparam logic [7:0]  CTRL_B_RESET = 8'h00;
   localparam logic [7:0]  CTRL_C_RESET = 8'h06;
   localparam logic [11:0] BAUD_RESET   = 12'h000;

   localparam logic [4:0]  DIV_NORMAL   = 5'h10;
   localparam logic [4:0]  DIV_DOUBLE   = 5'h08;
   localparam int          FRAME_W      = 13;
   localparam logic [1:0]  FIFO_DEPTH   = 2'h2;

   typedef struct packed {
      logic       frame_err;
      logic       parity_err;
      logic [8:0] data;
   } sp_rx_entry_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_RUN  = 3'b010,
      RX_DONE = 3'b100
   } sp_rx_state_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b01,
      TX_SHIFT = 2'b10
   } sp_tx_state_t;

endpackage : sp_pkg

// [verification/sp_serial_port_sva.sv]
// Port-level assertions for the serial port register block
`timescale 1ns/100ps
module sp_serial_port_sva
(
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cpu_status_word_ie,
   input wire logic        tx_complete_ack,
   input wire logic        receive_pin,
   input wire logic        receive_pin_owned,
   input wire logic        transmit_pin,
   input wire logic        transmit_pin_oe,
   input wire logic        rx_complete_irq,
   input wire logic        tx_complete_irq,
   input wire logic        buffer_empty_irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   chk_ready_pulse:
      assert property (pready |=> !pready) else $error("pready held too long");
   chk_ready_delay:
      assert property (psel && penable && !pready |=> pready) else $error("no answer in one cycle");
   chk_err_zero:
      assert property (pslverr |-> pready && prdata == 32'h0) else $error("error without zero data");
   chk_mapped_ok:
      assert property (pready && paddr <= 8'h10 && paddr[1:0] == 2'b00 |-> !pslverr)
         else $error("mapped address refused");
   chk_irq_global:
      assert property (!cpu_status_word_ie |=> !(rx_complete_irq || tx_complete_irq || buffer_empty_irq))
         else $error("interrupt without global enable");
   chk_ack_clears:
      assert property (tx_complete_ack |-> ##2 !tx_complete_irq) else $error("ack left interrupt up");
   chk_idle_high:
      assert property (!transmit_pin_oe |-> transmit_pin) else $error("released pin not high");
   chk_bit_length:
      assert property ($fell(transmit_pin) |-> !transmit_pin [*8]) else $error("bit shorter than 8");
   chk_start_owned:
      assert property ($fell(transmit_pin) |-> transmit_pin_oe) else $error("start bit without drive");
   chk_rx_irq_owned:
      assert property (rx_complete_irq |-> $past(receive_pin_owned)) else $error("rx irq while disabled");
endmodule : sp_serial_port_sva

bind sp_serial_port sp_serial_port_sva sp_serial_port_sva_inst (.*);

// [verification/sp_remote.sv]
// Remote serial station: drives the receive line, captures the transmit line
`timescale 1ns/100ps
module sp_remote
(
   input  wire logic sys_clk,
   input  wire logic transmit_pin,
   output logic      receive_pin
);
   initial receive_pin = 1'b1;

   // Start bit, nb frame bits LSB first, then one idle bit
   task automatic send(input logic [11:0] f, input int nb, input int bt);
      logic [12:0] s;
      s = {f, 1'b0};
      for (int k = 0; k <= nb; k++)
      begin
         receive_pin <= s[k];
         repeat (bt) @(posedge sys_clk);
      end
      receive_pin <= 1'b1;
      repeat (bt) @(posedge sys_clk);
   endtask : send

   // Returns at mid stop bit so a following start edge is not missed
   task automatic recv(input int nb, input int bt, output logic [8:0] d);
      d = 9'h000;
      while (transmit_pin !== 1'b0)
         @(posedge sys_clk);
      repeat (bt / 2) @(posedge sys_clk);
      for (int k = 0; k < nb; k++)
      begin
         repeat (bt) @(posedge sys_clk);
         d[k] = transmit_pin;
      end
      repeat (bt) @(posedge sys_clk);
   endtask : recv
endmodule : sp_remote

// [verification/tb.sv]
// Self-checking bench for the serial port register block
`timescale 1ns/100ps
module tb;
   logic        sys_clk;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ie;
   logic        ack;
   logic        rx_pin;
   logic        owned;
   logic        tx_pin;
   logic        tx_oe;
   logic        rx_irq;
   logic        tx_irq;
   logic        be_irq;
   logic [31:0] r;
   logic        e;
   logic [8:0]  d;
   logic [8:0]  d2;
   logic [2:0]  code;
   int          fail_count;
   int          n_checks;
   int          cyc;
   int          n;
   int          bt;

   sp_serial_port sp_serial_port_inst (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_status_word_ie(ie), .tx_complete_ack(ack), .receive_pin(rx_pin), .receive_pin_owned(owned),
      .transmit_pin(tx_pin), .transmit_pin_oe(tx_oe), .rx_complete_irq(rx_irq), .tx_complete_irq(tx_irq),
      .buffer_empty_irq(be_irq));
   sp_remote sp_remote_inst (.sys_clk(sys_clk), .transmit_pin(tx_pin), .receive_pin(rx_pin));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         conclude();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // Idle edge after release keeps psel from two writes in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(r, exp);
   endtask : rd

   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ie = 1'b0;
      ack = 1'b0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd(sp_pkg::OFF_STAT_A, 32'h20);
      rd(sp_pkg::OFF_CTRL_B, 32'h00);
      rd(sp_pkg::OFF_CTRL_C, 32'h06);
      rd(8'h14, 32'h0);
      cmp({31'h0, e}, 32'h1);
      $display("reset test done");
      ie <= 1'b1;
      wr(sp_pkg::OFF_CTRL_B, 32'h48);
      fork
         begin
            sp_remote_inst.recv(8, 16, d);
            sp_remote_inst.recv(8, 16, d2);
         end
         begin
            wr(sp_pkg::OFF_DATA, 32'hA5);
            wr(sp_pkg::OFF_DATA, 32'h3C);
            wr(sp_pkg::OFF_DATA, 32'h77);
         end
      join
      cmp({23'h0, d}, 32'hA5);
      cmp({23'h0, d2}, 32'h3C);
      repeat (16) @(posedge sys_clk);
      rd(sp_pkg::OFF_STAT_A, 32'h60);
      cmp({31'h0, tx_irq}, 32'h1);
      ack <= 1'b1;
      @(posedge sys_clk);
      ack <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(sp_pkg::OFF_STAT_A, 32'h20);
      fork
         sp_remote_inst.recv(8, 16, d);
         begin
            wr(sp_pkg::OFF_DATA, 32'h5A);
            wr(sp_pkg::OFF_CTRL_B, 32'h40);
            cmp({31'h0, tx_oe}, 32'h1);
         end
      join
      cmp({23'h0, d}, 32'h5A);
      repeat (16) @(posedge sys_clk);
      cmp({31'h0, tx_oe}, 32'h0);
      wr(sp_pkg::OFF_STAT_A, 32'hC0);
      rd(sp_pkg::OFF_STAT_A, 32'h20);
      $display("transmit test done");
      wr(sp_pkg::OFF_CTRL_B, 32'hB8);
      cmp({31'h0, owned}, 32'h1);
      for (int i = 0; i < 4; i++)
         sp_remote_inst.send({3'h0, i != 0, 8'(17 * (i + 1))}, 9, 16);
      rd(sp_pkg::OFF_STAT_A, 32'hB8);
      cmp({30'h0, rx_irq, be_irq}, 32'h3);
      rd(sp_pkg::OFF_DATA, 32'h11);
      rd(sp_pkg::OFF_STAT_A, 32'hA0);
      rd(sp_pkg::OFF_DATA, 32'h22);
      ie <= 1'b0;
      repeat (2) @(posedge sys_clk);
      cmp({30'h0, rx_irq, be_irq}, 32'h0);
      ie <= 1'b1;
      wr(sp_pkg::OFF_CTRL_B, 32'h08);
      rd(sp_pkg::OFF_STAT_A, 32'h20);
      cmp({31'h0, owned}, 32'h0);
      $display("receive test done");
      wr(sp_pkg::OFF_CTRL_B, 32'h18);
      for (int m = 0; m < 4; m++)
      begin
         wr(sp_pkg::OFF_CTRL_C, 32'(m * 16 + 6));
         sp_remote_inst.send(m > 1 ? 12'h201 : 12'h101, m > 1 ? 10 : 9, 16);
         rd(sp_pkg::OFF_STAT_A, m == 2 ? 32'hA4 : 32'hA0);
         rd(sp_pkg::OFF_DATA, 32'h01);
      end
      $display("parity test done");
      for (int i = 0; i < 5; i++)
      begin
         code = i == 4 ? 3'b111 : 3'(i);
         n = 5 + i;
         bt = (i % 2 == 1) ? 8 : 16;
         wr(sp_pkg::OFF_STAT_A, 32'(2 * (i % 2)));
         wr(sp_pkg::OFF_CTRL_C, {29'h0, code[1:0], 1'b0});
         wr(sp_pkg::OFF_CTRL_B, {27'h3, code[2], 2'b01});
         fork
            sp_remote_inst.recv(n, bt, d);
            wr(sp_pkg::OFF_DATA, 32'hFF);
         join
         cmp({23'h0, d}, 32'(9'h1FF >> (9 - n)));
         sp_remote_inst.send((12'h2 << n) - 12'h1, n + 1, bt);
         rd(sp_pkg::OFF_CTRL_B, {27'h3, code[2], n == 9, 1'b1});
         rd(sp_pkg::OFF_DATA, n > 8 ? 32'hFF : 32'(8'hFF >> (8 - n)));
      end
      $display("size test done");
      wr(sp_pkg::OFF_STAT_A, 32'h41);
      sp_remote_inst.send(12'h255, 10, 16);
      sp_remote_inst.send(12'h3AA, 10, 16);
      rd(sp_pkg::OFF_CTRL_B, 32'h1F);
      rd(sp_pkg::OFF_DATA, 32'hAA);
      rd(sp_pkg::OFF_STAT_A, 32'h21);
      $display("multiprocessor test done");
      conclude();
   end
endmodule : tb
